// [verilog/ldtt_defs.vh]
// constants for the line dip, interrupt and thermal trigger block
`ifndef LDTT_DEFS_VH
`define LDTT_DEFS_VH

// register addresses on the serial port (6-bit)
`define LDTT_ADDR_FLAGS 6'h04
`define LDTT_ADDR_FLAGS_RC 6'h05
`define LDTT_ADDR_MODE 6'h06
`define LDTT_ADDR_MASK 6'h07
`define LDTT_ADDR_DIP_THR 6'h08
`define LDTT_ADDR_DIP_CYC 6'h09
`define LDTT_ADDR_THERMAL 6'h0a
`define LDTT_ADDR_ZXT_LO 6'h0e
`define LDTT_ADDR_ZXT_HI 6'h0f

// command byte layout
`define LDTT_CMD_WR_BIT 7
`define LDTT_CMD_ADDR_MSB 5

// mode register fields
`define LDTT_MODE_DIP_DIS 3
`define LDTT_MODE_TEMP_GO 5

// interrupt flag positions
`define LDTT_FLAG_DIP 3
`define LDTT_FLAG_TEMP 5

// reset values
`define LDTT_RST_MODE 8'h00
`define LDTT_RST_MASK 8'h00
`define LDTT_RST_DIP_THR 8'h00
`define LDTT_RST_DIP_CYC 8'hff
`define LDTT_RST_ZXT 12'hfff

// timing in master clock cycles
`define LDTT_ZXT_PRESCALE 8'h80
`define LDTT_TEMP_DELAY 5'h18

`endif

// [verilog/ldtt_sync.v]
// two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module ldtt_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input wire core_clk,
	input wire arst_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	// meta_ff is read by sync_ff only
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // ldtt_sync
`default_nettype wire

// [verilog/ldtt_spi.v]
// serial port slave: command byte then one data byte, msb first
`timescale 1ns/1ps
`default_nettype none
`include "ldtt_defs.vh"
module ldtt_spi (
	input wire core_clk,
	input wire arst_n,
	input wire sclk_s,
	input wire cs_n_s,
	input wire din_s,
	input wire [7:0] rd_data,
	output wire [7:0] cmd,
	output wire cmd_done,
	output wire data_done,
	output wire [7:0] wr_data,
	output wire dout,
	output wire dout_oe_n
);
	reg sclk_d_ff;
	reg [4:0] bit_cnt_ff;
	reg [7:0] sh_in_ff;
	reg [7:0] cmd_ff;
	reg [7:0] sh_out_ff;
	reg dout_ff;
	reg cmd_done_ff;
	reg data_done_ff;
	wire fall;
	wire rise;

	assign fall = sclk_d_ff & ~sclk_s;
	assign rise = ~sclk_d_ff & sclk_s;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_d_ff <= 1'b1;
			bit_cnt_ff <= 5'h00;
			sh_in_ff <= 8'h00;
			cmd_ff <= 8'h00;
			sh_out_ff <= 8'h00;
			dout_ff <= 1'b0;
			cmd_done_ff <= 1'b0;
			data_done_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
			cmd_done_ff <= 1'b0;
			data_done_ff <= 1'b0;
			if (cs_n_s) begin
				bit_cnt_ff <= 5'h00;
			end else begin
				if (fall) begin
					sh_in_ff <= {sh_in_ff[6:0], din_s};
					// extra bytes in one frame are ignored
					if (bit_cnt_ff != 5'h10) begin
						bit_cnt_ff <= bit_cnt_ff + 5'h01;
					end
					if (bit_cnt_ff == 5'h07) begin
						cmd_ff <= {sh_in_ff[6:0], din_s};
						cmd_done_ff <= 1'b1;
					end
					if (bit_cnt_ff == 5'h0f) begin
						data_done_ff <= 1'b1;
					end
				end
				if (cmd_done_ff) begin
					dout_ff <= rd_data[7];
					sh_out_ff <= {rd_data[6:0], 1'b0};
				end else if (rise && bit_cnt_ff > 5'h08) begin
					// msb is held through the first data clock
					dout_ff <= sh_out_ff[7];
					sh_out_ff <= {sh_out_ff[6:0], 1'b0};
				end
			end
		end
	end

	assign cmd = cmd_ff;
	assign cmd_done = cmd_done_ff;
	assign data_done = data_done_ff;
	assign wr_data = sh_in_ff;
	assign dout = dout_ff;
	assign dout_oe_n = cs_n_s;
endmodule // ldtt_spi
`default_nettype wire

// [verilog/ldtt_top.v]
// dip detector, interrupt flags and thermal trigger of the metering core
// Overview of operation
// - count below-threshold half-cycles; alert low when count reaches cycle setting
// - dip event sets dip flag regardless of enable
// - enabled dip flag pulls interrupt request low
// - alert released once channel-2 magnitude reaches threshold
// - compare threshold with abs of msb byte of sample shifted left
// - below only when threshold strictly greater than that byte
// - while analog supply is low crossings, dip detection and the crossing timeout stay inactive
// - dip alert is low during reset
// - every event sets its flag independent of the mask
// - request low while any flag and its mask bit are set
// - reading 05h returns flags and clears them
// - request high at end of the read command byte
// - request held high until status byte shifted out, then re-evaluated
// - events during the clearing read stay pending
// - mode bit 5 starts temperature measurement at next zero crossing
// - at that crossing the sensor is routed into channel-1 converter
// - thermal reading written 24 master clocks after the crossing
// - finished conversion pulls request low when mask bit 5 set
// - thermal reading is signed, about one code per degree
// - 12-bit crossing timeout, 128-clock tick, reload on crossing, dip at zero
`timescale 1ns/1ps
`default_nettype none
`include "ldtt_defs.vh"
module ldtt_top #(
	parameter SAMPLE_W = 20
) (
	input wire core_clk,
	input wire arst_n,
	input wire sclk,
	input wire cs_n,
	input wire din,
	output wire dout,
	output wire dout_oe_n,
	input wire [SAMPLE_W-1:0] ch2_sample,
	input wire ch2_valid,
	input wire supply_ok,
	input wire [7:0] thermal_code,
	input wire [7:0] ext_events,
	output wire dip_alert_n_o,
	output wire dip_alert_n_oe_n,
	output wire irq_n_o,
	output wire irq_n_oe_n,
	output wire zero_cross_out,
	output wire temp_route_sel,
	output wire energy_accum_en
);
	wire sclk_s;
	wire cs_n_s;
	wire din_s;
	wire supply_s;
	wire [7:0] cmd;
	wire cmd_done;
	wire data_done;
	wire [7:0] wr_data;
	reg [7:0] rd_data;

	reg [7:0] mode_ff;
	reg [7:0] mask_ff;
	reg [7:0] thr_ff;
	reg [7:0] cyc_ff;
	reg [11:0] zxt_set_ff;
	reg [7:0] flags_ff;
	reg [7:0] thermal_ff;
	reg dip_alert_ff;
	reg [7:0] hc_cnt_ff;
	reg sign_ff;
	reg zc_ff;
	reg [6:0] pre_ff;
	reg [11:0] zxt_ff;
	reg temp_busy_ff;
	reg [4:0] temp_cnt_ff;
	reg irq_hold_ff;
	reg rc_pend_ff;

	wire [7:0] nxt_flags;
	wire [7:0] hw_evt;
	reg [7:0] mag;
	wire [SAMPLE_W-1:0] shifted;
	wire [7:0] msb_byte;
	wire below;
	wire zc;
	wire dip_hc_evt;
	wire dip_zxt_evt;
	wire dip_evt;
	wire temp_done;
	wire wr_en;
	wire rc_cmd;

	function [7:0] abs8;
		input [7:0] v;
		begin
			if (!v[7])
				abs8 = v;
			else if (v == 8'h80)
				// -128 has no positive byte, so it saturates
				abs8 = 8'h7f;
			else
				abs8 = ~v + 8'h01;
		end
	endfunction

	// one place that knows where the address sits in the command byte
	function [5:0] reg_addr;
		input [7:0] c;
		begin
			reg_addr = c[`LDTT_CMD_ADDR_MSB:0];
		end
	endfunction

	localparam [7:0] PRE_LAST8 = `LDTT_ZXT_PRESCALE - 8'h01;
	localparam [6:0] PRE_LAST = PRE_LAST8[6:0];

	// link pins and the supply monitor cross in through two flops

	ldtt_sync #(.WIDTH(4), .RST_VAL(4'b1110)) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.async_in({sclk, cs_n, din, supply_ok}),
		.sync_out({sclk_s, cs_n_s, din_s, supply_s})
	);

	ldtt_spi u_spi (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.sclk_s(sclk_s),
		.cs_n_s(cs_n_s),
		.din_s(din_s),
		.rd_data(rd_data),
		.cmd(cmd),
		.cmd_done(cmd_done),
		.data_done(data_done),
		.wr_data(wr_data),
		.dout(dout),
		.dout_oe_n(dout_oe_n)
	);

	assign wr_en = data_done & cmd[`LDTT_CMD_WR_BIT];
	assign rc_cmd = cmd_done & ~cmd[`LDTT_CMD_WR_BIT] &
		(reg_addr(cmd) == `LDTT_ADDR_FLAGS_RC);

	// dip comparison value from the shifted sample
	assign shifted = {ch2_sample[SAMPLE_W-2:0], 1'b0};
	always @* begin
		mag = abs8(shifted[SAMPLE_W-1:SAMPLE_W-8]);
	end
	assign msb_byte = mag;
	assign below = thr_ff > msb_byte;

	// sign change between samples marks a crossing
	// a zero sample counts as positive: only the sign bit is judged
	assign zc = ch2_valid & supply_s & (ch2_sample[SAMPLE_W-1] != sign_ff);
	// limitation: a cycle setting of 00h fires from the count only once it has saturated at FFh
	assign dip_hc_evt = zc & below & (hc_cnt_ff + 8'h01 == cyc_ff);
	assign dip_zxt_evt = supply_s & (pre_ff == PRE_LAST) &
		(zxt_ff == 12'h001);
	assign dip_evt = dip_hc_evt | dip_zxt_evt;
	assign temp_done = temp_busy_ff & (temp_cnt_ff == 5'h01);

	always @* begin
		case (reg_addr(cmd))
		`LDTT_ADDR_FLAGS: rd_data = flags_ff;
		`LDTT_ADDR_FLAGS_RC: rd_data = flags_ff;
		`LDTT_ADDR_MODE: rd_data = mode_ff;
		`LDTT_ADDR_MASK: rd_data = mask_ff;
		`LDTT_ADDR_DIP_THR: rd_data = thr_ff;
		`LDTT_ADDR_DIP_CYC: rd_data = cyc_ff;
		`LDTT_ADDR_THERMAL: rd_data = thermal_ff;
		`LDTT_ADDR_ZXT_LO: rd_data = zxt_set_ff[7:0];
		`LDTT_ADDR_ZXT_HI: rd_data = {4'h0, zxt_set_ff[11:8]};
		default: rd_data = 8'h00;
		endcase
	end

	// clear first, then events, so a late event survives the read
	assign hw_evt = ({7'h00, dip_evt} << `LDTT_FLAG_DIP) |
		({7'h00, temp_done} << `LDTT_FLAG_TEMP);
	genvar fi;
	generate
		for (fi = 0; fi < 8; fi = fi + 1) begin : g_flag
			assign nxt_flags[fi] = (flags_ff[fi] & ~rc_cmd) |
				ext_events[fi] | hw_evt[fi];
		end
	endgenerate

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= `LDTT_RST_MODE;
			mask_ff <= `LDTT_RST_MASK;
			thr_ff <= `LDTT_RST_DIP_THR;
			cyc_ff <= `LDTT_RST_DIP_CYC;
			zxt_set_ff <= `LDTT_RST_ZXT;
		end else if (wr_en) begin
			// read-only and unmapped addresses fall through unchanged
			case (reg_addr(cmd))
			`LDTT_ADDR_MODE: mode_ff <= wr_data;
			`LDTT_ADDR_MASK: mask_ff <= wr_data;
			`LDTT_ADDR_DIP_THR: thr_ff <= wr_data;
			`LDTT_ADDR_DIP_CYC: cyc_ff <= wr_data;
			`LDTT_ADDR_ZXT_LO: zxt_set_ff[7:0] <= wr_data;
			`LDTT_ADDR_ZXT_HI: zxt_set_ff[11:8] <= wr_data[3:0];
			default: mode_ff <= mode_ff;
			endcase
		end else if (zc && mode_ff[`LDTT_MODE_TEMP_GO]) begin
			// start bit self-clears once the conversion is launched
			mode_ff[`LDTT_MODE_TEMP_GO] <= 1'b0;
		end
	end

	// dip detection, held idle while the supply is low
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dip_alert_ff <= 1'b1;
			hc_cnt_ff <= 8'h00;
			sign_ff <= 1'b0;
			zc_ff <= 1'b0;
		end else if (!supply_s) begin
			hc_cnt_ff <= 8'h00;
		end else begin
			if (ch2_valid) begin
				sign_ff <= ch2_sample[SAMPLE_W-1];
				zc_ff <= ~ch2_sample[SAMPLE_W-1];
			end
			if (ch2_valid && !below) begin
				hc_cnt_ff <= 8'h00;
				dip_alert_ff <= 1'b0;
			end else if (zc) begin
				if (hc_cnt_ff != 8'hff)
					hc_cnt_ff <= hc_cnt_ff + 8'h01;
			end
			if (dip_evt && !mode_ff[`LDTT_MODE_DIP_DIS])
				dip_alert_ff <= 1'b1;
		end
	end

	// crossing timeout: 128-clock tick, stops at zero until next crossing
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_ff <= 7'h00;
			zxt_ff <= `LDTT_RST_ZXT;
		end else if (zc) begin
			pre_ff <= 7'h00;
			zxt_ff <= zxt_set_ff;
		end else if (supply_s) begin
			pre_ff <= pre_ff + 7'h01;
			if (pre_ff == PRE_LAST && zxt_ff != 12'h000)
				zxt_ff <= zxt_ff - 12'h001;
		end
	end

	// thermal conversion sequencer
	// thermal_code must be settled by the time the count expires
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			temp_busy_ff <= 1'b0;
			temp_cnt_ff <= 5'h00;
			thermal_ff <= 8'h00;
		end else if (!temp_busy_ff) begin
			if (zc && mode_ff[`LDTT_MODE_TEMP_GO]) begin
				temp_busy_ff <= 1'b1;
				temp_cnt_ff <= `LDTT_TEMP_DELAY;
			end
		end else begin
			temp_cnt_ff <= temp_cnt_ff - 5'h01;
			if (temp_done) begin
				temp_busy_ff <= 1'b0;
				thermal_ff <= thermal_code;
			end
		end
	end

	// request masking across a clearing status read
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_ff <= 8'h00;
			irq_hold_ff <= 1'b0;
			rc_pend_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			if (rc_cmd) begin
				irq_hold_ff <= 1'b1;
				rc_pend_ff <= 1'b1;
			end else if (rc_pend_ff && (data_done || cs_n_s)) begin
				// an aborted frame also frees the line
				irq_hold_ff <= 1'b0;
				rc_pend_ff <= 1'b0;
			end
		end
	end

	// open-drain pins: data tied low, only the enables move
	assign irq_n_o = 1'b0;
	assign irq_n_oe_n = ~(|(flags_ff & mask_ff)) | irq_hold_ff;
	assign dip_alert_n_o = 1'b0;
	assign dip_alert_n_oe_n = ~dip_alert_ff;
	assign zero_cross_out = zc_ff;
	assign temp_route_sel = temp_busy_ff;
	assign energy_accum_en = supply_s;
endmodule // ldtt_top
`default_nettype wire

// [verification/ldtt_host.sv]
// serial host model: one command byte and one data byte per frame
`timescale 1ns/1ps
`default_nettype none
module ldtt_host (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe_n,
	output logic rd_stb,
	output logic [7:0] rd_byte
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		rd_stb = 1'b0;
		rd_byte = 8'h00;
	end
	// link clock runs only inside frames, 80 ns period, idle high
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat);
		logic [15:0] w;
		logic [7:0] r;
		w = {cmd, dat};
		r = 8'h00;
		#7 cs_n = 1'b0;
		#33;
		for (int i = 15; i >= 0; i--) begin
			din = w[i];
			#20 sclk = 1'b0;
			// an undriven dout is never trusted
			if (i < 8)
				r = {r[6:0], dout_oe_n ? ~r[0] : dout};
			#40 sclk = 1'b1;
			#20;
		end
		#40 cs_n = 1'b1;
		din = ~din;
		if (!cmd[7]) begin
			rd_byte = r;
			rd_stb = 1'b1;
			#1 rd_stb = 1'b0;
		end
		#60;
	endtask
endmodule // ldtt_host
`default_nettype wire

// [verification/ldtt_top_asserts.sv]
// port assertions of the dip, interrupt and thermal block
`timescale 1ns/1ps
`default_nettype none
module ldtt_top_asserts #(
	parameter SAMPLE_W = 20
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic ch2_valid,
	input wire logic [SAMPLE_W-1:0] ch2_sample,
	input wire logic supply_ok,
	input wire logic dip_alert_n_o,
	input wire logic dip_alert_n_oe_n,
	input wire logic irq_n_o,
	input wire logic irq_n_oe_n,
	input wire logic temp_route_sel,
	input wire logic zero_cross_out,
	input wire logic energy_accum_en
);
	logic [7:0] route_cnt_ff;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// counts the sensor routing window; 24 is too long to unroll
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			route_cnt_ff <= 8'h00;
		else
			route_cnt_ff <= temp_route_sel ? route_cnt_ff + 8'h01 : 8'h00;
	end
	chk_reset_alert: assert property (
		$rose(arst_n) |-> !dip_alert_n_oe_n)
		else $error("alert not low out of reset");
	chk_pins_drive_low: assert property (
		!dip_alert_n_o && !irq_n_o)
		else $error("open drain data not low");
	chk_supply_idle: assert property (
		!supply_ok [*4] |-> !energy_accum_en)
		else $error("accumulation with supply low");
	chk_no_dip_unpowered: assert property (
		!energy_accum_en && !$past(energy_accum_en) |-> !$fell(dip_alert_n_oe_n))
		else $error("dip alert while supply low");
	chk_release_on_sample: assert property (
		$rose(dip_alert_n_oe_n) |-> $past(ch2_valid) ||
		$past(ch2_valid, 2) || $past(ch2_valid, 3))
		else $error("alert released without a sample");
	chk_route_at_cross: assert property (
		$rose(temp_route_sel) |-> $past(ch2_valid) ||
		$past(ch2_valid, 2) || $past(ch2_valid, 3))
		else $error("sensor routed without a sample");
	chk_route_length: assert property (
		$fell(temp_route_sel) |-> route_cnt_ff == 8'h18)
		else $error("sensor routing window wrong length");
	chk_irq_release_frame: assert property (
		$rose(irq_n_oe_n) |-> !$past(cs_n, 2) || !$past(cs_n, 3))
		else $error("request released outside a frame");
	chk_irq_hold_byte: assert property (
		$rose(irq_n_oe_n) |=> irq_n_oe_n [*8])
		else $error("request not held during status byte");
	chk_cross_level: assert property (
		ch2_valid && energy_accum_en |=>
		zero_cross_out == !$past(ch2_sample[SAMPLE_W-1]))
		else $error("crossing output does not follow sample sign");
endmodule // ldtt_top_asserts
bind ldtt_top ldtt_top_asserts #(.SAMPLE_W(SAMPLE_W))
	ldtt_top_asserts_inst (.core_clk, .arst_n, .cs_n, .ch2_valid,
	.ch2_sample, .supply_ok, .dip_alert_n_o, .dip_alert_n_oe_n,
	.irq_n_o, .irq_n_oe_n, .zero_cross_out, .temp_route_sel,
	.energy_accum_en);
`default_nettype wire

// [verification/ldtt_tb_top.sv]
// self-checking bench for the dip, interrupt and thermal block
`timescale 1ns/1ps
`default_nettype none
`include "ldtt_defs.vh"
`define CMP(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module ldtt_tb_top;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [19:0] ch2_sample = 20'h00000;
	logic ch2_valid = 1'b0;
	logic supply_ok = 1'b0;
	logic [7:0] thermal_code = 8'h00;
	logic [7:0] ext_events = 8'h00;
	logic pin_stb = 1'b0;
	logic [31:0] seed = 32'he668;
	logic [7:0] exp_q[$];
	logic [7:0] exp_v;
	logic [7:0] got_v;
	int error_cnt = 0;
	int comparisons = 0;
	wire sclk, cs_n, din, dout, dout_oe_n, rd_stb;
	wire [7:0] rd_byte;
	wire dip_alert_n_o, dip_alert_n_oe_n, irq_n_o, irq_n_oe_n;
	wire zero_cross_out, temp_route_sel, energy_accum_en;
	always #2.5 core_clk = ~core_clk;
	ldtt_top #(.SAMPLE_W(20)) ldtt_top_inst (.core_clk, .arst_n, .sclk,
		.cs_n, .din, .dout, .dout_oe_n, .ch2_sample, .ch2_valid,
		.supply_ok, .thermal_code, .ext_events, .dip_alert_n_o,
		.dip_alert_n_oe_n, .irq_n_o, .irq_n_oe_n, .zero_cross_out,
		.temp_route_sel, .energy_accum_en);
	ldtt_host ldtt_host_inst (.sclk, .cs_n, .din, .dout, .dout_oe_n,
		.rd_stb, .rd_byte);
	always @(posedge rd_stb or posedge pin_stb) begin
		exp_v = exp_q.pop_front();
		got_v = rd_stb ? rd_byte :
			{5'h00, energy_accum_en, irq_n_oe_n, dip_alert_n_oe_n};
		`CMP(got_v, exp_v)
	end
	function automatic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic print_verdict;
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		ldtt_host_inst.xfer({2'b00, a}, 8'h00);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		ldtt_host_inst.xfer({2'b10, a}, d);
	endtask
	// expected {accumulate, request oe_n, alert oe_n}
	task automatic pin(input logic [2:0] e);
		exp_q.push_back({5'h00, e});
		@(negedge core_clk) pin_stb = 1'b1;
		@(negedge core_clk) pin_stb = 1'b0;
	endtask
	task automatic wait_for(input logic [2:0] e, input int lim);
		int n;
		n = 0;
		while ({energy_accum_en, irq_n_oe_n, dip_alert_n_oe_n} !== e
			&& n < lim) begin
			@(negedge core_clk);
			n++;
		end
		if (n == lim) begin
			error_cnt++;
			print_verdict();
		end else begin
			pin(e);
		end
	endtask
	task automatic smp(input logic [19:0] s);
		@(negedge core_clk) ch2_sample = s;
		ch2_valid = 1'b1;
		@(negedge core_clk) ch2_valid = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask
	// random magnitude with top byte at most 20h, so below a 40h level
	task automatic below(input logic neg);
		logic [19:0] s;
		seed = lfsr(seed);
		s = {4'h0, seed[4:0], 1'b1, seed[9:0]};
		smp(neg ? -s : s);
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		pin(3'b010);
		arst_n = 1'b1;
		supply_ok = 1'b1;
		repeat (6) @(negedge core_clk);
		rd(6'h08, `LDTT_RST_DIP_THR);
		rd(6'h09, `LDTT_RST_DIP_CYC);
		rd(6'h07, `LDTT_RST_MASK);
		rd(6'h3f, 8'h00);
		wr(6'h08, 8'h40);
		wr(6'h09, 8'h03);
		wr(6'h07, 8'h08);
		rd(6'h08, 8'h40);
		smp(20'h20000);
		wait_for(3'b111, 20);
		below(1'b0);
		below(1'b1);
		below(1'b0);
		pin(3'b111);
		below(1'b1);
		wait_for(3'b100, 20);
		rd(6'h05, 8'h08);
		rd(6'h04, 8'h00);
		pin(3'b110);
		smp(20'h20000);
		wait_for(3'b111, 20);
		below(1'b1);
		below(1'b0);
		pin(3'b111);
		below(1'b1);
		wait_for(3'b100, 20);
		rd(6'h05, 8'h08);
		wr(6'h08, 8'h00);
		smp(20'h20000);
		wait_for(3'b111, 20);
		seed = lfsr(seed);
		thermal_code = seed[7:0];
		wr(6'h07, 8'h20);
		wr(6'h06, 8'h20);
		smp(-20'h20000);
		wait_for(3'b101, 60);
		rd(6'h0a, thermal_code);
		rd(6'h06, 8'h00);
		rd(6'h05, 8'h20);
		pin(3'b111);
		wr(6'h07, 8'h01);
		for (int b = 0; b < 8; b++) begin
			@(negedge core_clk) ext_events = 8'h01 << b;
			@(negedge core_clk) ext_events = 8'h00;
			rd(6'h04, 8'h01 << b);
			rd(6'h05, 8'h01 << b);
		end
		fork
			rd(6'h05, 8'h00);
			begin
				#900;
				@(negedge core_clk) ext_events = 8'h01;
				@(negedge core_clk) ext_events = 8'h00;
			end
		join
		wait_for(3'b101, 20);
		rd(6'h05, 8'h01);
		wr(6'h06, 8'h08);
		wr(6'h07, 8'h08);
		wr(6'h0e, 8'h02);
		wr(6'h0f, 8'h00);
		smp(20'h20000);
		wait_for(3'b101, 400);
		rd(6'h05, 8'h08);
		@(negedge core_clk) supply_ok = 1'b0;
		wr(6'h08, 8'h40);
		below(1'b1);
		below(1'b0);
		below(1'b1);
		wait_for(3'b011, 20);
		print_verdict();
	end
endmodule // ldtt_tb_top
`default_nettype wire
